/* File: design/tcis_pkg.sv */
// shared constants and types for the touch controller serial slave port
package tcis_pkg;

  // 7-bit slave addresses; the 8-bit bytes on the wire are these plus the direction bit
  localparam logic [6:0] TCIS_ADDR_PAIR_A = 7'h5D;  // answers 0xBA write / 0xBB read
  localparam logic [6:0] TCIS_ADDR_PAIR_B = 7'h14;  // answers 0x28 write / 0x29 read

  // bit counter marks inside one 9-clock byte
  localparam logic [3:0] TCIS_CNT_ZERO  = 4'h0;     // before the first data bit
  localparam logic [3:0] TCIS_CNT_LAST  = 4'h7;     // last data bit
  localparam logic [3:0] TCIS_ACK_SLOT  = 4'h8;     // eight bits seen, ninth clock next
  localparam logic [3:0] TCIS_BYTE_END  = 4'h9;     // ninth clock seen

  // cycles after reset release before the strap level is trusted
  localparam logic [1:0] TCIS_STRAP_WAIT = 2'h3;

  // pointer reset value and step
  localparam logic [15:0] TCIS_PTR_RST  = 16'h0000;
  localparam logic [15:0] TCIS_PTR_STEP = 16'h0001;

  // bus rate ceiling for the host (the bench host runs near 6250 kbps) and the core clock it is sampled with
  localparam int TCIS_BUS_MAX_KBPS = 400;
  localparam int TCIS_CLK_MHZ      = 100;

  // one written register byte handed to the user side
  typedef struct packed {
    logic [15:0] addr;  // register address
    logic [7:0]  data;  // byte written there
  } tcis_wr_t;

  // byte-level protocol states
  typedef enum logic [3:0] {
    TCIS_IDLE,    // waiting for a start
    TCIS_ADDR,    // receiving the slave address byte
    TCIS_REG_HI,  // receiving register address, upper byte
    TCIS_REG_LO,  // receiving register address, lower byte
    TCIS_WDATA,   // receiving data bytes
    TCIS_RDATA    // sending data bytes
  } tcis_state_t;

endpackage

/* File: design/tcis_slave.sv */
`timescale 1ns/1ps

// small synchronous fifo; output stage is a register so valid and data are flop driven
module tcis_fifo
  import tcis_pkg::*;
#(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // filling side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // draining side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];  // storage words
  logic [AW:0]      wptr_r;         // write pointer with wrap bit
  logic [AW:0]      rptr_r;         // read pointer with wrap bit
  logic             ovalid_r;       // output stage holds a word
  logic [WIDTH-1:0] odata_r;        // output stage word
  wire full_w  = (wptr_r[AW] != rptr_r[AW]) && (wptr_r[AW-1:0] == rptr_r[AW-1:0]);
  wire empty_w = (wptr_r == rptr_r);
  wire push_w  = in_valid_in && !full_w;
  wire pop_w   = !empty_w && (!ovalid_r || out_ready_in);  // refill output stage
  assign in_ready_out  = !full_w;
  assign out_valid_out = ovalid_r;
  assign out_data_out  = odata_r;
  // storage has no reset, it holds data only
  always_ff @(posedge clk_in) begin
    if (push_w) begin
      mem_r[wptr_r[AW-1:0]] <= in_data_in;
    end
  end
  // pointers and output stage
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wptr_r   <= '0;
      rptr_r   <= '0;
      ovalid_r <= 1'b0;
      odata_r  <= '0;
    end else begin
      if (push_w) wptr_r <= wptr_r + 1'b1;
      if (pop_w) begin
        rptr_r  <= rptr_r + 1'b1;
        odata_r <= mem_r[rptr_r[AW-1:0]];
      end
      if (pop_w) ovalid_r <= 1'b1;
      else if (out_ready_in) ovalid_r <= 1'b0;
    end
  end
endmodule // tcis_fifo

// Summary of operation
// - slave only; host starts every transfer
// - strap picks one of two address pairs
// - matching address acknowledged on ninth clock
// - wrong address: no ack, idle till start
// - nine clocks per byte, receiver acknowledges
// - sample on clock high, change on low
// - address lsb zero writes, one reads
// - write: 16-bit register address, then data
// - pointer steps by one per written byte
// - read streams until host not-acknowledges
module tcis_slave
  import tcis_pkg::*;
#(
  parameter int MEM_AW     = 8,  // low pointer bits that index the register array
  parameter int FIFO_DEPTH = 8   // words buffered toward the user side
) (
  // clock and reset
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RESET_N_IN,
  // serial bus, open drain
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_N_OUT,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_N_OUT,
  // address strap, level of the interrupt pin around reset release
  input  wire logic        INT_STRAP_IN,
  // written bytes toward the user side
  output logic             WR_VALID_OUT,
  input  wire logic        WR_READY_IN,
  output logic [15:0]      WR_ADDR_OUT,
  output logic [7:0]       WR_DATA_OUT,
  // status
  output logic             ADDR_SEL_OUT,
  output logic             BUSY_OUT
);
  localparam int MEM_DEPTH = 1 << MEM_AW;
  // synchronisers, stage 1 read only by stage 2
  logic        scl_s1_r, scl_s2_r, scl_s3_r;   // clock pin pipeline
  logic        sda_s1_r, sda_s2_r, sda_s3_r;   // data pin pipeline
  logic        int_s1_r, int_s2_r;             // strap pipeline
  // strap capture
  logic [1:0]  strap_cnt_r;                    // settle counter after release
  logic        strap_done_r;                   // strap caught
  logic        addr_sel_r;                     // 1 selects pair B
  // protocol state
  tcis_state_t state_r;                        // byte-level state
  logic [3:0]  bit_cnt_r;                      // rising edges in this byte
  logic [7:0]  shift_r;                        // received bits
  logic [7:0]  tx_r;                           // bits left to send
  logic        rw_r;                           // direction of this address phase
  logic        host_ack_r;                     // host acked the last sent byte
  logic [15:0] ptr_r;                          // register address pointer
  logic        sda_oe_n_r;                     // low pulls data line
  logic        scl_oe_n_r;                     // low stretches the clock
  logic [7:0]  mem_r [MEM_DEPTH];              // register array
  // pin edges and bus conditions from settled samples only
  wire rise_w  = scl_s2_r && !scl_s3_r;
  wire fall_w  = !scl_s2_r && scl_s3_r;
  wire start_w = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
  wire stop_w  = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;
  // decode of the address byte against the strapped pair
  wire [6:0] own_addr_w = addr_sel_r ? TCIS_ADDR_PAIR_B : TCIS_ADDR_PAIR_A;
  wire       match_w    = (shift_r[7:1] == own_addr_w);
  wire       ack_fall_w = fall_w && (bit_cnt_r == TCIS_ACK_SLOT);
  wire       end_fall_w = fall_w && (bit_cnt_r == TCIS_BYTE_END);
  // write byte waits in the ack slot until the fifo takes it
  wire       wslot_w  = (state_r == TCIS_WDATA) && (bit_cnt_r == TCIS_ACK_SLOT)
                        && (ack_fall_w || !scl_oe_n_r);
  wire       fifo_rdy_w;
  wire       push_w   = wslot_w && fifo_rdy_w;
  wire [MEM_AW-1:0] idx_w = ptr_r[MEM_AW-1:0];
  wire       load_w   = end_fall_w && !start_w && !stop_w &&
                        (((state_r == TCIS_ADDR) && rw_r) ||
                         ((state_r == TCIS_RDATA) && host_ack_r));
  tcis_wr_t  fifo_in_w;
  tcis_wr_t  fifo_out_w;
  assign fifo_in_w = '{addr: ptr_r, data: shift_r};
  // pointer after one step, shared by write and read paths
  function automatic logic [15:0] ptr_step(input logic [15:0] p);
    ptr_step = p + TCIS_PTR_STEP;
  endfunction
  // output pins: the line is only ever pulled low, never driven high
  assign SCL_OUT      = 1'b0;
  assign SDA_OUT      = 1'b0;
  assign SCL_OE_N_OUT = scl_oe_n_r;
  assign SDA_OE_N_OUT = sda_oe_n_r;
  assign ADDR_SEL_OUT = addr_sel_r;
  assign WR_ADDR_OUT  = fifo_out_w.addr;
  assign WR_DATA_OUT  = fifo_out_w.data;
  // two-flop synchronisers plus one history stage for edges
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'h7;
      {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'h7;
      {int_s1_r, int_s2_r}           <= 2'h0;
    end else begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= {SCL_IN, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_s3_r} <= {SDA_IN, sda_s1_r, sda_s2_r};
      {int_s1_r, int_s2_r}           <= {INT_STRAP_IN, int_s1_r};
    end
  end
  // strap is caught once, a few cycles after release, then frozen
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      strap_cnt_r  <= '0;
      strap_done_r <= 1'b0;
      addr_sel_r   <= 1'b0;
    end else if (!strap_done_r) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == TCIS_STRAP_WAIT) begin
        strap_done_r <= 1'b1;
        addr_sel_r   <= int_s2_r;
      end
    end
  end
  // register array write port; read is asynchronous for the send path
  always_ff @(posedge CORE_CLK_IN) begin
    if (push_w) begin
      mem_r[idx_w] <= shift_r;
    end
  end
  // bit sampling and counting; only clock-high levels count as data
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      bit_cnt_r  <= TCIS_CNT_ZERO;
      shift_r    <= '0;
      host_ack_r <= 1'b0;
    end else if (start_w || stop_w || end_fall_w) begin
      bit_cnt_r <= TCIS_CNT_ZERO;
    end else if (rise_w && state_r != TCIS_IDLE) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      if (bit_cnt_r < TCIS_ACK_SLOT) shift_r <= {shift_r[6:0], sda_s2_r};
      else host_ack_r <= !sda_s2_r;
    end
  end
  // byte-level protocol; everything waits for the host to clock it
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_r    <= TCIS_IDLE;
      rw_r       <= 1'b0;
      ptr_r      <= TCIS_PTR_RST;
      tx_r       <= '0;
      sda_oe_n_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
    end else if (start_w) begin
      state_r    <= TCIS_ADDR;
      sda_oe_n_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
    end else if (stop_w) begin
      state_r    <= TCIS_IDLE;
      sda_oe_n_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
    end else if (wslot_w) begin
      // hold the clock low while the fifo is full, so no byte is ever lost
      scl_oe_n_r <= fifo_rdy_w;
      if (fifo_rdy_w) begin
        sda_oe_n_r <= 1'b0;
        ptr_r      <= ptr_step(ptr_r);
      end
    end else if (ack_fall_w) begin
      case (state_r)
        TCIS_ADDR: begin
          if (match_w) begin
            sda_oe_n_r <= 1'b0;
            rw_r       <= shift_r[0];
          end else begin
            state_r <= TCIS_IDLE;
          end
        end
        TCIS_REG_HI: begin
          ptr_r[15:8] <= shift_r;
          sda_oe_n_r  <= 1'b0;
        end
        TCIS_REG_LO: begin
          ptr_r[7:0] <= shift_r;
          sda_oe_n_r <= 1'b0;
        end
        TCIS_RDATA: begin
          sda_oe_n_r <= 1'b1;        // host owns the ninth bit
        end
        default: begin
          sda_oe_n_r <= 1'b1;
        end
      endcase
    end else if (end_fall_w) begin
      // end of ninth clock: release, or put the first bit of a read byte out
      sda_oe_n_r <= 1'b1;
      case (state_r)
        TCIS_ADDR:   state_r <= rw_r ? TCIS_RDATA : TCIS_REG_HI;
        TCIS_REG_HI: state_r <= TCIS_REG_LO;
        TCIS_REG_LO: state_r <= TCIS_WDATA;
        TCIS_WDATA:  state_r <= TCIS_WDATA;
        TCIS_RDATA:  state_r <= host_ack_r ? TCIS_RDATA : TCIS_IDLE;
        default:     state_r <= TCIS_IDLE;
      endcase
      if (load_w) begin
        tx_r       <= mem_r[idx_w];
        sda_oe_n_r <= mem_r[idx_w][7];
        ptr_r      <= ptr_step(ptr_r);
      end
    end else if (fall_w && state_r == TCIS_RDATA && bit_cnt_r != TCIS_CNT_ZERO
                 && bit_cnt_r <= TCIS_CNT_LAST) begin
      // next bit changes only while the clock is low
      tx_r       <= {tx_r[6:0], 1'b0};
      sda_oe_n_r <= tx_r[6];
    end
  end
  // busy while addressed; registered for a clean status pin
  always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) BUSY_OUT <= 1'b0;
    else BUSY_OUT <= (state_r != TCIS_IDLE) && (state_r != TCIS_ADDR);
  end
  // written bytes wait here for the user side
  tcis_fifo #(
    .WIDTH ($bits(tcis_wr_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CORE_CLK_IN),
    .rst_n_in      (RESET_N_IN),
    .in_valid_in   (push_w),
    .in_ready_out  (fifo_rdy_w),
    .in_data_in    (fifo_in_w),
    .out_valid_out (WR_VALID_OUT),
    .out_ready_in  (WR_READY_IN),
    .out_data_out  (fifo_out_w)
  );
  // checks next to the logic they guard
  a_start_enters_addr: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    start_w |=> (state_r == TCIS_ADDR) && (bit_cnt_r == TCIS_CNT_ZERO) && sda_oe_n_r)
    else $error("start did not enter address phase");
  a_stop_to_idle: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (stop_w && !start_w) |=> (state_r == TCIS_IDLE) && sda_oe_n_r && scl_oe_n_r)
    else $error("stop did not return to idle");
  a_match_acks: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (ack_fall_w && state_r == TCIS_ADDR && match_w && !start_w && !stop_w)
    |=> !sda_oe_n_r && (rw_r == $past(shift_r[0])))
    else $error("matching address not acknowledged");
  a_miss_no_ack: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (ack_fall_w && state_r == TCIS_ADDR && !match_w && !start_w && !stop_w)
    |=> (state_r == TCIS_IDLE) && sda_oe_n_r)
    else $error("foreign address acknowledged");
  a_rx_release_end: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (end_fall_w && !start_w && !stop_w &&
     (state_r == TCIS_REG_HI || state_r == TCIS_REG_LO || state_r == TCIS_WDATA))
    |=> sda_oe_n_r && (bit_cnt_r == TCIS_CNT_ZERO))
    else $error("data line not released after ninth clock");
  a_sda_change_low: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    ($changed(sda_oe_n_r) && !$past(start_w) && !$past(stop_w)) |-> !$past(scl_s2_r))
    else $error("data line moved while clock high");
  a_write_step: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    push_w |=> (ptr_r == ptr_step($past(ptr_r))) && !sda_oe_n_r
               && (mem_r[$past(idx_w)] == $past(shift_r)))
    else $error("write did not store and step pointer");
  a_read_step: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    load_w |=> (ptr_r == ptr_step($past(ptr_r))) && (state_r == TCIS_RDATA))
    else $error("read did not step pointer");
  a_read_nack_ends: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    (end_fall_w && state_r == TCIS_RDATA && !host_ack_r && !start_w && !stop_w)
    |=> (state_r == TCIS_IDLE) && sda_oe_n_r)
    else $error("read went on after not-acknowledge");
  a_stretch_only_wslot: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    !scl_oe_n_r |-> (state_r == TCIS_WDATA) && (bit_cnt_r == TCIS_ACK_SLOT) && !fifo_rdy_w
                    || $past(!fifo_rdy_w))
    else $error("clock held low outside a full-fifo wait");
  a_strap_frozen: assert property (@(posedge CORE_CLK_IN) disable iff (!RESET_N_IN)
    $past(strap_done_r) |-> $stable(addr_sel_r))
    else $error("address pair changed after capture");
endmodule // tcis_slave

/* File: dv/tcis_host_model.sv */
`timescale 1ns/1ps

// behavioural host master on an open-drain bus; it only pulls lines, never drives high
module tcis_host_model (
  // core clock paces the host, four cycles to a quarter bit
  input  wire logic clk_in,
  // resolved wire levels
  input  wire logic scl_in,
  input  wire logic sda_in,
  // pulls toward ground
  output logic      scl_pull_out,
  output logic      sda_pull_out
);
  int hang_cnt;     // stretches that never ended
  int stretch_cnt;  // cycles spent on a held clock

  initial begin
    scl_pull_out = 1'b0;
    sda_pull_out = 1'b0;
    hang_cnt     = 0;
    stretch_cnt  = 0;
  end

  // quarter bit; 160 ns per bit puts the rate near 6250 kbps, far over 400 kbps
  task automatic qtr();
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  // let the clock go high, honour a stretch for a bounded time only
  task automatic scl_up();
    int n;
    n = 0;
    scl_pull_out = 1'b0;
    #1;
    while (scl_in !== 1'b1 && n < 20000) begin
      @(posedge clk_in);
      #1;
      n++;
      stretch_cnt++;
    end
    if (n >= 20000) hang_cnt++;
  endtask

  // start or repeated start: data falls while clock is high
  task automatic start();
    sda_pull_out = 1'b0;
    qtr();
    scl_up();
    qtr();
    sda_pull_out = 1'b1;
    qtr();
    scl_pull_out = 1'b1;
    qtr();
  endtask

  // stop: data rises while clock is high
  task automatic stop();
    sda_pull_out = 1'b1;
    qtr();
    scl_up();
    qtr();
    sda_pull_out = 1'b0;
    qtr();
  endtask

  // one bit: change while low, sample in the middle of high
  task automatic xbit(input logic b, output logic r);
    sda_pull_out = ~b;
    qtr();
    scl_up();
    qtr();
    r = sda_in;
    qtr();
    scl_pull_out = 1'b1;
    qtr();
  endtask

  // eight bits msb first, ninth clock carries the answer
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask

  // receive eight bits, acknowledge to go on, not-acknowledge on the last
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(~ack, r);
  endtask
endmodule // tcis_host_model

/* File: dv/tcis_slave_tb_top.sv */
`timescale 1ns/1ps

// bench: host model on the wire side, random-ready sink on the user side
module tcis_slave_tb_top;
  import tcis_pkg::*;

  logic       core_clk, reset_n, strap, wr_ready, ready_en;
  logic       scl_oe_n, sda_oe_n, wr_valid, addr_sel, busy;
  logic       scl_pull, sda_pull;
  logic [15:0] wr_addr;
  logic [7:0]  wr_data;
  wire logic  scl_w, sda_w;   // pulled-up wires
  int         n_fail, num_checks, seed, ptr;
  logic [7:0] mem [int];      // expected register contents
  tcis_wr_t   exp_q [$];      // words the user side must see

  // open drain: low if anyone pulls, else the pull-up wins
  assign scl_w = ~(scl_pull | ~scl_oe_n);
  assign sda_w = ~(sda_pull | ~sda_oe_n);

  tcis_slave DUT (
    .CORE_CLK_IN (core_clk), .RESET_N_IN (reset_n),
    .SCL_IN (scl_w), .SCL_OUT (), .SCL_OE_N_OUT (scl_oe_n),
    .SDA_IN (sda_w), .SDA_OUT (), .SDA_OE_N_OUT (sda_oe_n),
    .INT_STRAP_IN (strap),
    .WR_VALID_OUT (wr_valid), .WR_READY_IN (wr_ready),
    .WR_ADDR_OUT (wr_addr), .WR_DATA_OUT (wr_data),
    .ADDR_SEL_OUT (addr_sel), .BUSY_OUT (busy)
  );

  tcis_host_model host (
    .clk_in (core_clk), .scl_in (scl_w), .sda_in (sda_w),
    .scl_pull_out (scl_pull), .sda_pull_out (sda_pull)
  );

  // 100 MHz core clock
  initial core_clk = 1'b0;
  always #5 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // random sink; a gate lets a test stall it on purpose
  always @(posedge core_clk) begin
    #1;
    wr_ready = ready_en && ($random(seed) & 1);
  end

  // every accepted word checked against the queue
  always @(posedge core_clk) begin
    if (reset_n && wr_valid === 1'b1 && wr_ready) begin
      if (exp_q.size() == 0) chk("wr_extra", 24'h0, {wr_addr, wr_data});
      else chk("wr_word", exp_q.pop_front(), {wr_addr, wr_data});
    end
  end

  // reset with a strap level held through release
  task automatic do_reset(input logic s);
    reset_n = 1'b0;
    strap   = s;
    repeat (16) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    ptr = TCIS_PTR_RST;
    repeat (12) @(posedge core_clk);
    #1;
    chk("addr_sel", {23'h0, s}, {23'h0, addr_sel});
    chk("busy_idle", 24'h0, {23'h0, busy});
  endtask

  // write burst; pointer model steps by one per byte
  task automatic wr_burst(input logic [6:0] a, input logic [15:0] r, input int n);
    logic ack;
    logic [7:0] d;
    host.start();
    host.wbyte({a, 1'b0}, ack);
    chk("ack_addr_w", 24'h1, {23'h0, ack});
    host.wbyte(r[15:8], ack);
    host.wbyte(r[7:0], ack);
    ptr = r;
    for (int i = 0; i < n; i++) begin
      d = $random(seed);
      mem[ptr & 8'hFF] = d;
      exp_q.push_back({ptr[15:0], d});
      host.wbyte(d, ack);
      chk("ack_data", 24'h1, {23'h0, ack});
      ptr = (ptr + 1) & 16'hFFFF;
    end
    host.stop();
  endtask

  // read burst; without setp it continues from the current pointer
  task automatic rd_burst(input logic [6:0] a, input logic [15:0] r, input int n,
                          input logic setp);
    logic ack;
    logic [7:0] d;
    if (setp) begin
      host.start();
      host.wbyte({a, 1'b0}, ack);
      host.wbyte(r[15:8], ack);
      host.wbyte(r[7:0], ack);
      ptr = r;
    end
    host.start();
    host.wbyte({a, 1'b1}, ack);
    chk("ack_addr_r", 24'h1, {23'h0, ack});
    for (int i = 0; i < n; i++) begin
      host.rbyte(i < n - 1, d);
      chk("rd_data", {16'h0, mem[ptr & 8'hFF]}, {16'h0, d});
      ptr = (ptr + 1) & 16'hFFFF;
    end
    host.stop();
  endtask

  // wrong address: no answer, and none to a later byte either
  task automatic bad_addr(input logic [6:0] a);
    logic ack;
    host.start();
    host.wbyte({a, 1'b0}, ack);
    chk("nack_addr", 24'h0, {23'h0, ack});
    host.wbyte(8'h5A, ack);
    chk("nack_after", 24'h0, {23'h0, ack});
    host.stop();
  endtask

  // wait for the sink to take everything, bounded
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 2000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("drained", 24'h0, exp_q.size());
    chk("valid_idle", 24'h0, {23'h0, wr_valid});
    if (n >= 2000) tally_and_finish();
  endtask

  // hang guard for the whole run
  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    $display("BAD watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial begin
    n_fail = 0;
    num_checks = 0;
    seed = 27;
    ready_en = 1'b1;
    wr_ready = 1'b0;
    do_reset(1'b0);
    // burst across the 0xFF boundary, read back in two parts
    wr_burst(TCIS_ADDR_PAIR_A, 16'h00FD, 5);
    drain();
    rd_burst(TCIS_ADDR_PAIR_A, 16'h00FD, 3, 1'b1);
    rd_burst(TCIS_ADDR_PAIR_A, 16'h0000, 2, 1'b0);
    $display("test pair_a_rw done");
    bad_addr(TCIS_ADDR_PAIR_B);
    $display("test wrong_addr done");
    // sink stalled: buffer fills, clock is held until the sink returns
    ready_en = 1'b0;
    fork
      wr_burst(TCIS_ADDR_PAIR_A, 16'h0020, 11);
      begin
        repeat (1000) @(posedge core_clk);
        #1;
        chk("busy", 24'h1, {23'h0, busy});
        repeat (2000) @(posedge core_clk);
        #1;
        chk("valid_held", 24'h1, {23'h0, wr_valid});
        ready_en = 1'b1;
      end
    join
    drain();
    chk("stretched", 24'h1, {23'h0, host.stretch_cnt > 0});
    $display("test fifo_full done");
    // second reset mid-run, other pair
    do_reset(1'b1);
    wr_burst(TCIS_ADDR_PAIR_B, 16'h0040, 2);
    drain();
    rd_burst(TCIS_ADDR_PAIR_B, 16'h0040, 2, 1'b1);
    bad_addr(TCIS_ADDR_PAIR_A);
    $display("test pair_b done");
    chk("hangs", 24'h0, host.hang_cnt);
    tally_and_finish();
  end
endmodule // tcis_slave_tb_top
